// file: logic/gtc_core_bank.sv
// One core's banked comparator, step value, control bits and event flag
`timescale 1ns/100ps
module gtc_core_bank
    import gtc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       clk_en,
    // Shared counter
    input  wire logic [63:0]                count,
    // Write side
    input  wire gtc_pkg::gtc_bank_wr_type   wr,
    input  wire logic [31:0]                wdata,
    // Banked state
    output      gtc_pkg::gtc_bank_ctrl_type ctrl_q,
    output      logic                       flag_q,
    output      logic [63:0]                cmp_q,
    output      logic [31:0]                step_q
);
    // Next values
    gtc_bank_ctrl_type ctrl_d;
    logic              flag_d;
    logic [63:0]       cmp_d;
    logic [31:0]       step_d;
    logic              match;

    // Next-state computation
    always_comb begin
        ctrl_d = ctrl_q;
        flag_d = flag_q;
        cmp_d  = cmp_q;
        step_d = step_q;
        // Fires on greater-or-equal, gated by compare enable
        match  = ctrl_q.comp_en && (count >= cmp_q); // RL8 RL18
        // Control bits banked per core
        if (wr.ctrl) begin
            ctrl_d.comp_en  = wdata[GTC_CTRL_CMP_EN]; // RL8
            ctrl_d.irq_en   = wdata[GTC_CTRL_IRQ_EN]; // RL9
            ctrl_d.auto_inc = wdata[GTC_CTRL_AUTO];   // RL10
        end
        // Write one clears, write zero keeps
        if (wr.status && wdata[GTC_STAT_FLAG]) begin
            flag_d = 1'b0; // RL13
        end
        // Match sets flag; set wins over a same-cycle clear
        if (match) begin
            flag_d = 1'b1; // RL12
        end
        // Periodic mode adds step; single shot leaves comparator
        if (match && ctrl_q.auto_inc) begin
            cmp_d = cmp_q + {32'h0000_0000, step_q}; // RL11 RL10
        end
        // Software writes take priority over auto step
        if (wr.cmp_lo) begin
            cmp_d[31:0] = wdata; // RL14
        end
        if (wr.cmp_hi) begin
            cmp_d[63:32] = wdata; // RL14
        end
        if (wr.step) begin
            step_d = wdata; // RL16
        end
    end

    // State registers, frozen while clock enable is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= '0; // RL1
            flag_q <= 1'b0;
            cmp_q  <= GTC_RST_DWORD;
            step_q <= GTC_RST_WORD;
        end else if (clk_en) begin
            ctrl_q <= ctrl_d;
            flag_q <= flag_d;
            cmp_q  <= cmp_d;
            step_q <= step_d;
        end
    end
endmodule : gtc_core_bank

// file: logic/gtc_top.sv
// Shared 64-bit global timer with per-core banked comparators
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
//
// Contract
// RL1: Seven zero-reset registers at region 0x200
// RL2: Counter low at 0x00, high at 0x04
// RL3: Software uses single 32-bit accesses only
// RL4: Load count: disable, low, high, enable
// RL5: Read high, low, high; retry on mismatch
// RL6: Prescaler in control bits 15:8
// RL7: Control bit 0 gates counting
// RL8: Banked bit 1 enables comparison
// RL9: Banked bit 2 raises interrupt 27
// RL10: Banked bit 3 low means single shot
// RL11: Auto mode adds step on each match
// RL12: Banked sticky event flag set on match
// RL13: Flag cleared only by writing one
// RL14: Banked comparator at 0x10 and 0x14
// RL15: Software disables compare while updating comparator
// RL16: Banked step value register at 0x18
// RL17: Matches never disturb the shared counter
// RL18: Compare fires on greater or equal
// RL19: Runs on the peripheral clock
// RL20: Counting ignores core debug halt
// RL21: One tick per prescaler plus one cycles
// RL22: Event flag in status bit 0
module gtc_top
    import gtc_pkg::*;
(
    // Peripheral clock, reset and clock enable
    input  wire logic                                     clk,
    input  wire logic                                     rst,
    input  wire logic                                     clk_en,
    // Register port
    input  wire logic [gtc_pkg::GTC_ADDR_W-1:0]           reg_addr,
    input  wire logic [gtc_pkg::GTC_CORE_W-1:0]           reg_core,
    input  wire logic [31:0]                              reg_wdata,
    input  wire logic                                     reg_wr,
    input  wire logic                                     reg_rd,
    output      logic [31:0]                              reg_rdata,
    // Per-core interrupt pending levels toward the distributor
    output      logic [gtc_pkg::GTC_NUM_CORES-1:0]        irq_pending,
    // Shared counter view
    output      logic [63:0]                              count_out
);
    import gtc_pkg::*;

    // Block overview
    // One shared 64-bit up-counter, one prescaler, one enable
    // Four banked comparator blocks, one per core
    // Core picked by the register port's core select
    // Counter halves are plain words, no shadow latch
    // Software must stop the timer before loading halves
    // Software must re-read the high half around the low
    // Comparator halves are plain words as well
    // Software should drop compare enable while updating
    // Otherwise a half-written comparator can fire early
    // Compare is greater-or-equal, so a late setup still fires
    // Single shot keeps firing while count stays ahead
    // Auto mode adds the step once per matching cycle
    // A small step may need several cycles to catch up
    // A zero step in auto mode leaves the flag re-setting
    // Event flag is sticky; a set beats a same-cycle clear
    // Interrupt level is flag and enable, one cycle later
    // Read data stands one cycle, then returns to zero
    // Unmapped or unaligned reads return zero
    // Writes to unmapped addresses are dropped
    // Control write updates global and banked fields
    // Global fields: enable bit and prescaler
    // Banked fields: compare, interrupt and auto bits
    // Prescaler change mid-count keeps the divider's running count
    // Divider holds its phase while the timer is off
    // Clock enable low freezes every register here
    // No debug-halt input: counting never pauses for it
    // Counter writes win over a tick in the same cycle

    // Address match against one register of the region
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a == (GTC_REGION_BASE + off));
    endfunction : hit

    // Shared counter state
    logic [63:0]       count_q;
    logic [63:0]       count_d;
    // Prescaler divider
    logic [7:0]        pre_cnt_q;
    logic [7:0]        pre_cnt_d;
    // Global control fields
    logic              tmr_en_q;
    logic              tmr_en_d;
    logic [7:0]        prescale_q;
    logic [7:0]        prescale_d;
    // Read data and interrupt registers
    logic [31:0]       rdata_q;
    logic [31:0]       rdata_d;
    logic [GTC_NUM_CORES-1:0] irq_q;
    logic [GTC_NUM_CORES-1:0] irq_d;
    // Decoded accesses
    logic              wr_cnt_lo;
    logic              wr_cnt_hi;
    logic              wr_ctrl;
    logic              tick;
    // Banked signals per core
    gtc_bank_wr_type   bank_wr    [GTC_NUM_CORES];
    gtc_bank_ctrl_type bank_ctrl  [GTC_NUM_CORES];
    logic              bank_flag  [GTC_NUM_CORES];
    logic [63:0]       bank_cmp   [GTC_NUM_CORES];
    logic [31:0]       bank_step  [GTC_NUM_CORES];

    // Write decode of global registers
    always_comb begin
        wr_cnt_lo = 1'b0;
        wr_cnt_hi = 1'b0;
        wr_ctrl   = 1'b0;
        if (reg_wr && hit(reg_addr, GTC_OFF_CNT_LO)) begin
            wr_cnt_lo = 1'b1; // RL2
        end else if (reg_wr && hit(reg_addr, GTC_OFF_CNT_HI)) begin
            wr_cnt_hi = 1'b1; // RL2
        end else if (reg_wr && hit(reg_addr, GTC_OFF_CTRL)) begin
            wr_ctrl = 1'b1;
        end
    end

    // Banked write strobes go only to the addressed core
    always_comb begin
        for (int i = 0; i < GTC_NUM_CORES; i++) begin
            bank_wr[i] = '0;
            if (reg_wr && (reg_core == i[GTC_CORE_W-1:0])) begin
                bank_wr[i].ctrl   = hit(reg_addr, GTC_OFF_CTRL);
                bank_wr[i].status = hit(reg_addr, GTC_OFF_STATUS);
                bank_wr[i].cmp_lo = hit(reg_addr, GTC_OFF_CMP_LO);
                bank_wr[i].cmp_hi = hit(reg_addr, GTC_OFF_CMP_HI);
                bank_wr[i].step   = hit(reg_addr, GTC_OFF_STEP);
            end
        end
    end

    // Global control fields
    always_comb begin
        tmr_en_d   = tmr_en_q;
        prescale_d = prescale_q;
        if (wr_ctrl) begin
            tmr_en_d   = reg_wdata[GTC_CTRL_TMR_EN]; // RL7
            prescale_d = reg_wdata[GTC_CTRL_PRE_MSB:GTC_CTRL_PRE_LSB]; // RL6
        end
    end

    // Prescaler: tick once every prescale plus one enabled cycles
    always_comb begin
        pre_cnt_d = pre_cnt_q;
        tick      = 1'b0;
        if (tmr_en_q) begin
            if (pre_cnt_q >= prescale_q) begin
                pre_cnt_d = 8'h00;
                tick      = 1'b1; // RL21
            end else begin
                pre_cnt_d = pre_cnt_q + 8'h01; // RL21
            end
        end
    end

    // Shared counter; comparator activity never touches it
    always_comb begin
        count_d = count_q;
        // Holds when disabled, steps on each tick
        if (tick) begin
            count_d = count_q + 64'h1; // RL7 RL17 RL20
        end
        // Software halves override a same-cycle tick
        if (wr_cnt_lo) begin
            count_d[31:0] = reg_wdata; // RL2
        end
        if (wr_cnt_hi) begin
            count_d[63:32] = reg_wdata; // RL2
        end
    end

    // Read mux; data stands in the cycle after the strobe only
    always_comb begin
        rdata_d = GTC_RST_WORD;
        if (!reg_rd) begin
            rdata_d = GTC_RST_WORD;
        end else if (hit(reg_addr, GTC_OFF_CNT_LO)) begin
            rdata_d = count_q[31:0]; // RL2
        end else if (hit(reg_addr, GTC_OFF_CNT_HI)) begin
            rdata_d = count_q[63:32]; // RL2
        end else if (hit(reg_addr, GTC_OFF_CTRL)) begin
            // Reserved bits read zero
            rdata_d[GTC_CTRL_PRE_MSB:GTC_CTRL_PRE_LSB] = prescale_q; // RL6
            rdata_d[GTC_CTRL_TMR_EN] = tmr_en_q;
            rdata_d[GTC_CTRL_CMP_EN] = bank_ctrl[reg_core].comp_en;
            rdata_d[GTC_CTRL_IRQ_EN] = bank_ctrl[reg_core].irq_en;
            rdata_d[GTC_CTRL_AUTO]   = bank_ctrl[reg_core].auto_inc;
        end else if (hit(reg_addr, GTC_OFF_STATUS)) begin
            rdata_d[GTC_STAT_FLAG] = bank_flag[reg_core]; // RL22
        end else if (hit(reg_addr, GTC_OFF_CMP_LO)) begin
            rdata_d = bank_cmp[reg_core][31:0]; // RL14
        end else if (hit(reg_addr, GTC_OFF_CMP_HI)) begin
            rdata_d = bank_cmp[reg_core][63:32]; // RL14
        end else if (hit(reg_addr, GTC_OFF_STEP)) begin
            rdata_d = bank_step[reg_core]; // RL16
        end else begin
            // Unmapped address reads zero
            rdata_d = GTC_RST_WORD;
        end
    end

    // Interrupt pending per core: flag gated by its enable
    always_comb begin
        for (int i = 0; i < GTC_NUM_CORES; i++) begin
            irq_d[i] = bank_flag[i] && bank_ctrl[i].irq_en; // RL9
        end
    end

    // Global state registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q    <= GTC_RST_DWORD; // RL1
            pre_cnt_q  <= GTC_RST_PRE;
            tmr_en_q   <= 1'b0;
            prescale_q <= GTC_RST_PRE;
        end else if (clk_en) begin
            count_q    <= count_d; // RL19
            pre_cnt_q  <= pre_cnt_d;
            tmr_en_q   <= tmr_en_d;
            prescale_q <= prescale_d;
        end
    end

    // Output registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= GTC_RST_WORD;
            irq_q   <= '0;
        end else if (clk_en) begin
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    // One banked comparator block per core
    generate
        for (genvar g = 0; g < GTC_NUM_CORES; g++) begin : g_bank
            gtc_core_bank u_bank (
                .clk    (clk),
                .clk_en (clk_en),
                .rst    (rst),
                .count  (count_q),
                .wr     (bank_wr[g]),
                .wdata  (reg_wdata),
                .ctrl_q (bank_ctrl[g]),
                .flag_q (bank_flag[g]),
                .cmp_q  (bank_cmp[g]),
                .step_q (bank_step[g])
            );
        end
    endgenerate

    // Outputs straight from flip-flops
    assign reg_rdata   = rdata_q;
    assign irq_pending = irq_q;
    assign count_out   = count_q;
endmodule : gtc_top

// file: pkg/gtc_pkg.sv
// Shared constants and carrier types for the global timer block
package gtc_pkg;
    // Bank count and widths
    localparam int          GTC_NUM_CORES    = 4;
    localparam int          GTC_CORE_W       = 2;
    localparam int          GTC_ADDR_W       = 12;
    // Region placement above the private region base
    localparam logic [11:0] GTC_REGION_BASE  = 12'h200;
    // Register offsets inside the region
    localparam logic [11:0] GTC_OFF_CNT_LO   = 12'h000;
    localparam logic [11:0] GTC_OFF_CNT_HI   = 12'h004;
    localparam logic [11:0] GTC_OFF_CTRL     = 12'h008;
    localparam logic [11:0] GTC_OFF_STATUS   = 12'h00C;
    localparam logic [11:0] GTC_OFF_CMP_LO   = 12'h010;
    localparam logic [11:0] GTC_OFF_CMP_HI   = 12'h014;
    localparam logic [11:0] GTC_OFF_STEP     = 12'h018;
    // Control field positions
    localparam int          GTC_CTRL_TMR_EN  = 0;
    localparam int          GTC_CTRL_CMP_EN  = 1;
    localparam int          GTC_CTRL_IRQ_EN  = 2;
    localparam int          GTC_CTRL_AUTO    = 3;
    localparam int          GTC_CTRL_PRE_LSB = 8;
    localparam int          GTC_CTRL_PRE_MSB = 15;
    // Status field position
    localparam int          GTC_STAT_FLAG    = 0;
    // Reset values
    localparam logic [31:0] GTC_RST_WORD     = 32'h0000_0000;
    localparam logic [63:0] GTC_RST_DWORD    = 64'h0;
    localparam logic [7:0]  GTC_RST_PRE      = 8'h00;
    // Shared per-core interrupt number toward the distributor
    localparam int          GTC_IRQ_ID       = 27;

    // Banked control bits
    typedef struct packed {
        logic auto_inc;
        logic irq_en;
        logic comp_en;
    } gtc_bank_ctrl_type;

    // Banked write strobes for one core
    typedef struct packed {
        logic ctrl;
        logic status;
        logic cmp_lo;
        logic cmp_hi;
        logic step;
    } gtc_bank_wr_type;
endpackage : gtc_pkg

// file: testbench/gtc_assertions.sv
// Port-level checker for the global timer block
`timescale 1ns/100ps
module gtc_assertions
    import gtc_pkg::*;
(
    // Clock, reset, enable
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        clk_en,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [1:0]  reg_core,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Outputs toward distributor and observer
    input wire logic [3:0]  irq_pending,
    input wire logic [63:0] count_out
);
    logic       en_q;  // Mirror of the timer enable
    logic [7:0] pre_q; // Mirror of the prescaler
    wire        rd_ok = clk_en && reg_rd;
    // Track global control bits from control writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q <= 1'b0;
            pre_q <= 8'h00;
        end else if (clk_en && reg_wr && reg_addr == 12'h208) begin
            en_q <= reg_wdata[0];
            pre_q <= reg_wdata[15:8];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // No register write of any kind for three cycles
    sequence s_quiet; !reg_wr[*3]; endsequence
    property p_rd_idle; clk_en && !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_unmap;
        rd_ok && (reg_addr < 12'h200 || reg_addr > 12'h218
            || reg_addr[1:0] != 2'h0) |=> reg_rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_ctl_rsv;
        rd_ok && reg_addr == 12'h208
            |=> reg_rdata[31:16] == 16'h0 && reg_rdata[7:4] == 4'h0;
    endproperty
    a_ctl_rsv: assert property (p_ctl_rsv) else $error("ctrl rsv");
    property p_stat;
        rd_ok && reg_addr == 12'h20C |=> reg_rdata[31:1] == 31'h0;
    endproperty
    a_stat: assert property (p_stat) else $error("status bits");
    property p_freeze;
        !clk_en |=> $stable(count_out) && $stable(irq_pending);
    endproperty
    a_freeze: assert property (p_freeze) else $error("not frozen");
    property p_step;
        s_quiet |-> count_out == $past(count_out)
            || count_out == $past(count_out) + 64'h1;
    endproperty
    a_step: assert property (p_step) else $error("count jump");
    property p_gate; (!en_q && !reg_wr)[*3] |-> $stable(count_out); endproperty
    a_gate: assert property (p_gate) else $error("count moved");
    property p_run;
        (clk_en && en_q && pre_q == 8'h00 && !reg_wr)[*3]
            |-> count_out == $past(count_out) + 64'h1;
    endproperty
    a_run: assert property (p_run) else $error("count stuck");
    property p_irq_fall;
        ($past(irq_pending) & ~irq_pending) != 4'h0
            |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq lost");
endmodule : gtc_assertions
bind gtc_top gtc_assertions u_chk (.clk, .rst, .clk_en, .reg_addr,
    .reg_core, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_pending,
    .count_out);

// file: testbench/gtc_irq_sink.sv
// Distributor stand-in recording pending interrupt lines
`timescale 1ns/100ps
module gtc_irq_sink (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Pending lines and record clear
    input  wire logic [3:0] irq_pending,
    input  wire logic       clr,
    // Cores seen pending since clear
    output      logic [3:0] seen_q
);
    // Sticky record per core line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_q <= 4'h0;
        end else if (clr) begin
            seen_q <= 4'h0;
        end else begin
            seen_q <= seen_q | irq_pending;
        end
    end
endmodule : gtc_irq_sink

// file: testbench/test_gtc_top.sv
// Self-checking bench for the global timer block
`timescale 1ns/100ps
module test_gtc_top;
    import gtc_pkg::*;
    logic        clk = 1'b0;      // Peripheral clock
    logic        rst = 1'b1;      // Reset
    logic        clk_en = 1'b1;   // Clock enable
    logic [11:0] reg_addr = 12'h0;
    logic [1:0]  reg_core = 2'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0]  irq_pending;
    logic [63:0] count_out;
    logic        clr = 1'b0;      // Sink record clear
    logic [3:0]  seen_q;
    logic [31:0] lfsr = 32'hD8A13566;
    logic [31:0] d;
    logic [31:0] mem [12];        // Banked values written
    logic [63:0] c;
    logic [7:0]  p;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          n;
    always #5 clk = ~clk;
    gtc_top DUT (.clk, .rst, .clk_en, .reg_addr, .reg_core, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .irq_pending, .count_out);
    gtc_irq_sink u_sink (.clk, .rst, .irq_pending, .clr, .seen_q);
    // Random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    // Comparator after auto adds past a held count
    function automatic logic [63:0] auto_cmp(input logic [63:0] t, b, s);
        return b + s * ((t - b) / s + 64'h1);
    endfunction : auto_cmp
    // Control word from prescaler and low bits
    function automatic logic [31:0] ctl(input logic [7:0] q, logic [3:0] b);
        return {16'h0, q, 4'h0, b};
    endfunction : ctl
    task automatic check(input string nm, input logic [63:0] s, e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic conclude();
        if (mismatches == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    // One-cycle write
    task automatic wr(input logic [11:0] a, logic [1:0] k, logic [31:0] v);
        reg_addr <= a;
        reg_core <= k;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask : wr
    // One-cycle read, data taken in the following cycle
    task automatic rd(input logic [11:0] a, logic [1:0] k,
                      output logic [31:0] v);
        reg_addr <= a;
        reg_core <= k;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        #1 v = reg_rdata;
    endtask : rd
    task automatic idle(input int m);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (m) @(posedge clk);
    endtask : idle
    // High, low, high read until consistent
    task automatic rd64(output logic [63:0] v);
        logic [31:0] h0, l, h1;
        rd(12'h204, 2'h0, h1);
        do begin
            h0 = h1;
            rd(12'h200, 2'h0, l);
            rd(12'h204, 2'h0, h1);
        end while (h0 !== h1);
        v = {h1, l};
    endtask : rd64
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            rd(12'h200 + 12'(4 * i), 2'h3, d);
            check("reset", d, 32'h0);
        end
        // Banked comparator and step values
        for (int j = 0; j < 12; j++) begin
            lfsr = lfsr_next(lfsr);
            mem[j] = lfsr;
            wr(12'h210 + 12'(4 * (j % 3)), 2'(j / 3), lfsr);
        end
        for (int j = 0; j < 12; j++) begin
            rd(12'h210 + 12'(4 * (j % 3)), 2'(j / 3), d);
            check("bank", d, mem[j]);
        end
        wr(12'h208, 2'h3, 32'hFFFFFFFF);
        rd(12'h208, 2'h3, d);
        check("ctrl", d, 32'h0000FF0F);
        wr(12'h208, 2'h3, 32'h0);
        wr(12'h21C, 2'h0, 32'h5);
        rd(12'h21C, 2'h0, d);
        check("unmapped", d, 32'h0);
        rd(12'h201, 2'h0, d);
        check("unaligned", d, 32'h0);
        // Load near a carry and read it consistently
        wr(12'h200, 2'h0, 32'hFFFFFFFE);
        wr(12'h204, 2'h0, 32'h1);
        wr(12'h208, 2'h0, 32'h1);
        rd64(c);
        check("carry", c >= 64'h1FFFFFFFE && c < 64'h200000020, 1'b1);
        wr(12'h208, 2'h0, 32'h0);
        rd64(c);
        idle(5);
        check("held", count_out, c);
        // Tick spacing for a few prescalers
        for (int j = 0; j < 3; j++) begin
            lfsr = lfsr_next(lfsr);
            p = (j == 0) ? 8'h00 : {5'h0, lfsr[2:0]};
            wr(12'h208, 2'h0, ctl(p, 4'h1));
            idle(1);
            c = count_out;
            while (count_out === c) @(negedge clk);
            c = count_out;
            n = 0;
            while (count_out === c) begin
                @(negedge clk);
                n++;
            end
            check("tick gap", n, p + 8'h1);
        end
        // Single shot on core 1 with count past comparator
        wr(12'h208, 2'h1, 32'h0);
        wr(12'h200, 2'h1, 32'd100);
        wr(12'h204, 2'h1, 32'h0);
        wr(12'h210, 2'h1, 32'd50);
        wr(12'h214, 2'h1, 32'h0);
        wr(12'h208, 2'h1, ctl(8'h0, 4'h6));
        idle(3);
        check("irq", irq_pending, 4'b0010);
        rd(12'h20C, 2'h1, d);
        check("flag", d, 32'h1);
        rd(12'h210, 2'h1, d);
        check("single", d, 32'd50);
        wr(12'h20C, 2'h1, 32'h0);
        rd(12'h20C, 2'h1, d);
        check("w0", d, 32'h1);
        rd(12'h20C, 2'h0, d);
        check("other bank", d, 32'h0);
        wr(12'h208, 2'h1, ctl(8'h0, 4'h4));
        wr(12'h20C, 2'h1, 32'h1);
        idle(3);
        rd(12'h20C, 2'h1, d);
        check("w1c", d, 32'h0);
        check("irq off", irq_pending, 4'h0);
        check("sink", seen_q, 4'b0010);
        // Auto increment on core 2
        wr(12'h200, 2'h2, 32'd20);
        wr(12'h204, 2'h2, 32'h0);
        wr(12'h210, 2'h2, 32'd20);
        wr(12'h214, 2'h2, 32'h0);
        wr(12'h218, 2'h2, 32'd5);
        wr(12'h208, 2'h2, ctl(8'h0, 4'hA));
        idle(4);
        rd(12'h210, 2'h2, d);
        check("auto", d, 32'd25);
        check("count kept", count_out, 64'd20);
        wr(12'h208, 2'h2, ctl(8'h0, 4'hB));
        idle(30);
        wr(12'h208, 2'h2, ctl(8'h0, 4'hA));
        idle(4);
        c = count_out;
        rd(12'h210, 2'h2, d);
        check("periodic", d, auto_cmp(c, 64'd20, 64'd5));
        // Clock enable low freezes counting
        wr(12'h208, 2'h0, 32'h1);
        idle(3);
        clk_en <= 1'b0;
        @(negedge clk);
        c = count_out;
        repeat (5) @(negedge clk);
        check("clk_en", count_out, c);
        @(posedge clk);
        clk_en <= 1'b1;
        idle(4);
        conclude();
    end
endmodule : test_gtc_top
